// [pkg/mcod_params.svh]
/*
 * Constants of the microcore output instruction decoder: register offsets,
 * reset values, instruction masks and patterns, field positions and timing.
 * Assumes it is included by bare name after the package that holds the types.
 */
`ifndef MCOD_PARAMS_SVH
`define MCOD_PARAMS_SVH

// ****************************************************************
// Register word offsets on the Avalon-MM slave, decoded from address bits 7:2.
// ****************************************************************
`define MCOD_OFS_DRIVE_RIGHT 6'h00
`define MCOD_OFS_COMP_RIGHT 6'h01
`define MCOD_OFS_SHORTCUT 6'h02
`define MCOD_OFS_ADDR_BASE 6'h03
`define MCOD_OFS_DRIVE_STATE 6'h04
`define MCOD_OFS_MODE_STATE 6'h05
`define MCOD_OFS_FLAGS 6'h06

// ****************************************************************
// Reset values.
// ****************************************************************
`define MCOD_RST_DRIVE_RIGHT 12'h000
`define MCOD_RST_COMP_RIGHT 4'h0
`define MCOD_RST_SHORTCUT 12'hCCC
`define MCOD_RST_ADDR_BASE 6'h00
`define MCOD_RST_DRIVE 12'h000
`define MCOD_RST_COMP 4'h0
`define MCOD_RST_SLEW 1'b0
`define MCOD_RST_FLAGS 16'h0000

// ****************************************************************
// Instruction masks and patterns.
// ****************************************************************
`define MCOD_MASK_STO 16'hFFC0
`define MCOD_PAT_STO 16'h3480
`define MCOD_PAT_STOS 16'h3440
`define MCOD_MASK_STOC 16'hFFF8
`define MCOD_PAT_STOC 16'h3550
`define MCOD_MASK_SLEW 16'hFFFE
`define MCOD_PAT_SLEW 16'h3596
`define MCOD_MASK_FLAG 16'hFFE0
`define MCOD_PAT_FLAG 16'h3700
`define MCOD_MASK_STORE 16'hC003
`define MCOD_PAT_STORE 16'h8001

// ****************************************************************
// Field positions, target limits and timing counts.
// ****************************************************************
`define MCOD_F_TARGET_LSB 2
`define MCOD_F_COMP_SW 2
`define MCOD_F_STORE_MODE 13
`define MCOD_F_STORE_ADDR_LSB 2
`define MCOD_F_FLAG_LEVEL 4
`define MCOD_UNDEF_TARGET 4'hC
`define MCOD_SLEW_RISE_CYC 1
`define MCOD_SLEW_FALL_CYC 4

`endif

// [pkg/mcod_pkg.sv]
/*
 * Types of the microcore output instruction decoder.
 * Assumes nothing of its surroundings.
 */
package mcod_pkg;

    typedef enum logic [1:0] {
        MCOD_KEEP = 2'h0,
        MCOD_OFF = 2'h1,
        MCOD_ON = 2'h2,
        MCOD_TOGGLE = 2'h3
    } mcod_drive_code_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
        logic [15:0] src_value;
    } mcod_instr_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [15:0] data;
    } mcod_dram_wr_t;

endpackage : mcod_pkg

// [core/mcod_slew_timer.sv]
/*
 * Edge-speed timer: applies a fast request after the rise delay and a
 * normal request after the fall delay. Assumes set_fast and set_slow are
 * one-cycle pulses on the same clock and never high together.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcod_params.svh"

module mcod_slew_timer #(
    parameter int RISE_CYC = `MCOD_SLEW_RISE_CYC,
    parameter int FALL_CYC = `MCOD_SLEW_FALL_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic set_fast,
    input wire logic set_slow,
    output logic fast_eff
);
    import mcod_pkg::*;

    logic [2:0] cnt;
    logic pend;

    always_ff @(posedge clock) begin
        if (rst) begin
            fast_eff <= `MCOD_RST_SLEW;
            cnt <= 3'h0;
            pend <= `MCOD_RST_SLEW;
        end else if (ce) begin
            if (set_fast || set_slow) begin
                pend <= set_fast;
                if ((set_fast ? RISE_CYC : FALL_CYC) == 1) begin
                    fast_eff <= set_fast;
                    cnt <= 3'h0;
                end else begin
                    cnt <= 3'((set_fast ? RISE_CYC : FALL_CYC) - 1);
                end
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
                if (cnt == 3'h1) begin
                    fast_eff <= pend;
                end
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_quiet;
        ce && !set_fast && !set_slow;
    endsequence
    sequence s_slow_req;
        ce && set_slow && fast_eff && cnt == 3'h0;
    endsequence

    property p_rise;
        ce && set_fast |=> fast_eff;
    endproperty
    a_rise: assert property (p_rise) else $error("fast edge speed not active one cycle later");

    property p_fall;
        s_slow_req ##1 s_quiet[*3] |=> !fast_eff;
    endproperty
    a_fall: assert property (p_fall) else $error("normal edge speed not active four cycles later");

    property p_fall_hold;
        s_slow_req ##1 s_quiet[*2] |-> fast_eff;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("normal edge speed applied too early");

endmodule : mcod_slew_timer
`default_nettype wire

// [core/mcod_dram_store.sv]
/*
 * Data RAM store stage: forms the line address in immediate or indexed
 * mode and registers a one-cycle write. Assumes the RAM takes the write
 * on the cycle that we is high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcod_params.svh"

module mcod_dram_store (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic exec,
    input wire logic indexed,
    input wire logic [5:0] line,
    input wire logic [5:0] base,
    input wire logic [15:0] data,
    output mcod_pkg::mcod_dram_wr_t wr
);
    import mcod_pkg::*;

    always_ff @(posedge clock) begin
        if (rst) begin
            wr <= '0;
        end else if (ce) begin
            wr.we <= exec;
            if (exec) begin
                wr.addr <= indexed ? 6'(line + base) : line;
                wr.data <= data;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_store;
        ce && exec |=> wr.we && wr.data == $past(data)
            && wr.addr == ($past(indexed) ? 6'($past(line) + $past(base)) : $past(line));
    endproperty
    a_store: assert property (p_store) else $error("data RAM store address or data wrong");

endmodule : mcod_dram_store
`default_nettype wire

// [core/mcod_decode.sv]
/*
 * Microcore output instruction decoder: executes the single-output,
 * shortcut-output, offset-compensation, data RAM store, edge-speed and
 * status-bit instructions. Rights, shortcuts and the address base are
 * programmed over an Avalon-MM slave with waitrequest.
 * Assumes the sequencer presents one instruction word per valid cycle on
 * the same clock, with the value of its source register beside it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcod_params.svh"

module mcod_decode (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire mcod_pkg::mcod_instr_t instr,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [4:0] hs_drive,
    output logic [6:0] ls_drive,
    output logic [3:0] comp_enable,
    output logic edge_speed_fast,
    output mcod_pkg::mcod_dram_wr_t dram_wr,
    output logic [15:0] flags
);
    import mcod_pkg::*;

    // ****************************************************************
    // Helper functions.
    // ****************************************************************
    function automatic logic opcode_hit(input logic [15:0] w, input logic [15:0] mask,
                                        input logic [15:0] pat);
        return (w & mask) == pat;
    endfunction : opcode_hit

    function automatic logic apply_code(input logic cur, input logic [1:0] code);
        unique case (mcod_drive_code_t'(code))
            MCOD_KEEP: return cur;
            MCOD_OFF: return 1'b0;
            MCOD_ON: return 1'b1;
            MCOD_TOGGLE: return !cur;
        endcase
    endfunction : apply_code

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction : byte_merge

    // ****************************************************************
    // Architectural state.
    // ****************************************************************
    logic [11:0] drive_right_config;
    logic [3:0] comp_right;
    logic [11:0] shortcut_cfg;
    logic [5:0] addr_base;
    logic [11:0] drive;
    logic [11:0] next_drive;
    logic edge_speed_select;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic bus_wr;

    assign hs_drive = drive[4:0];
    assign ls_drive = drive[11:5];

    // ****************************************************************
    // Instruction decode.
    // ****************************************************************
    logic exec;
    logic is_sto;
    logic is_stos;
    logic is_stoc;
    logic is_slew;
    logic is_flag;
    logic is_store;
    logic [3:0] target_driver_select;
    logic [1:0] sto_code;
    logic [1:0] comp_block_select;
    logic comp_sw;
    logic [3:0] flag_bit_index;
    logic flag_level;
    logic sto_ok;
    logic slew_ok;
    logic sel_bit_now;

    assign exec = ce && instr.valid;
    assign is_sto = exec && opcode_hit(instr.word, `MCOD_MASK_STO, `MCOD_PAT_STO);
    assign is_stos = exec && opcode_hit(instr.word, `MCOD_MASK_STO, `MCOD_PAT_STOS);
    assign is_stoc = exec && opcode_hit(instr.word, `MCOD_MASK_STOC, `MCOD_PAT_STOC);
    assign is_slew = exec && opcode_hit(instr.word, `MCOD_MASK_SLEW, `MCOD_PAT_SLEW);
    assign is_flag = exec && opcode_hit(instr.word, `MCOD_MASK_FLAG, `MCOD_PAT_FLAG);
    assign is_store = exec && opcode_hit(instr.word, `MCOD_MASK_STORE, `MCOD_PAT_STORE);

    assign target_driver_select = instr.word[`MCOD_F_TARGET_LSB +: 4];
    assign sto_code = instr.word[1:0];
    assign comp_block_select = instr.word[1:0];
    assign comp_sw = instr.word[`MCOD_F_COMP_SW];
    assign flag_bit_index = instr.word[3:0];
    assign flag_level = instr.word[`MCOD_F_FLAG_LEVEL];
    assign sel_bit_now = drive[target_driver_select];

    // Codes at or above the undefined value address nothing.
    assign sto_ok = target_driver_select < `MCOD_UNDEF_TARGET
        && drive_right_config[target_driver_select];

    // Edge speed affects every output, so every drive right is needed.
    assign slew_ok = &drive_right_config;

    // ****************************************************************
    // Pre-driver output state.
    // ****************************************************************
    always_comb begin
        next_drive = drive;
        if (is_sto && sto_ok) begin
            next_drive[target_driver_select] = apply_code(drive[target_driver_select], sto_code);
        end
        if (is_stos) begin
            for (int k = 0; k < 3; k++) begin
                if (shortcut_cfg[4*k +: 4] < `MCOD_UNDEF_TARGET
                    && drive_right_config[shortcut_cfg[4*k +: 4]]) begin
                    next_drive[shortcut_cfg[4*k +: 4]] =
                        apply_code(drive[shortcut_cfg[4*k +: 4]], instr.word[4-2*k +: 2]);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            drive <= `MCOD_RST_DRIVE;
        end else if (ce) begin
            drive <= next_drive;
        end
    end

    // ****************************************************************
    // Offset compensation enables.
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            comp_enable <= `MCOD_RST_COMP;
        end else if (is_stoc && comp_right[comp_block_select]) begin
            comp_enable[comp_block_select] <= comp_sw;
        end
    end

    // ****************************************************************
    // Edge speed selection and its delayed effect.
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            edge_speed_select <= `MCOD_RST_SLEW;
        end else if (is_slew && slew_ok) begin
            edge_speed_select <= instr.word[0];
        end
    end

    mcod_slew_timer #(
        .RISE_CYC(`MCOD_SLEW_RISE_CYC),
        .FALL_CYC(`MCOD_SLEW_FALL_CYC)
    ) u_slew (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .set_fast(is_slew && slew_ok && instr.word[0]),
        .set_slow(is_slew && slew_ok && !instr.word[0]),
        .fast_eff(edge_speed_fast)
    );

    // ****************************************************************
    // Status register bit writes.
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            flags <= `MCOD_RST_FLAGS;
        end else if (is_flag) begin
            flags[flag_bit_index] <= flag_level;
        end
    end

    // ****************************************************************
    // Data RAM store.
    // ****************************************************************
    mcod_dram_store u_store (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .exec(is_store),
        .indexed(instr.word[`MCOD_F_STORE_MODE]),
        .line(instr.word[`MCOD_F_STORE_ADDR_LSB +: 6]),
        .base(addr_base),
        .data(instr.src_value),
        .wr(dram_wr)
    );

    // ****************************************************************
    // Avalon-MM register slave.
    // ****************************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (avs_address[7:2])
            `MCOD_OFS_DRIVE_RIGHT: rd_word[11:0] = drive_right_config;
            `MCOD_OFS_COMP_RIGHT: rd_word[3:0] = comp_right;
            `MCOD_OFS_SHORTCUT: rd_word[11:0] = shortcut_cfg;
            `MCOD_OFS_ADDR_BASE: rd_word[5:0] = addr_base;
            `MCOD_OFS_DRIVE_STATE: rd_word[11:0] = drive;
            `MCOD_OFS_MODE_STATE: rd_word[5:0] = {edge_speed_select, edge_speed_fast, comp_enable};
            `MCOD_OFS_FLAGS: rd_word[15:0] = flags;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign wr_word = byte_merge(rd_word, avs_writedata, avs_byteenable);
    assign bus_wr = ce && avs_write && !avs_waitrequest;

    // Every access waits exactly one cycle; read data are captured then.
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            drive_right_config <= `MCOD_RST_DRIVE_RIGHT;
            comp_right <= `MCOD_RST_COMP_RIGHT;
            shortcut_cfg <= `MCOD_RST_SHORTCUT;
            addr_base <= `MCOD_RST_ADDR_BASE;
        end else if (bus_wr) begin
            unique case (avs_address[7:2])
                `MCOD_OFS_DRIVE_RIGHT: drive_right_config <= wr_word[11:0];
                `MCOD_OFS_COMP_RIGHT: comp_right <= wr_word[3:0];
                `MCOD_OFS_SHORTCUT: shortcut_cfg <= wr_word[11:0];
                `MCOD_OFS_ADDR_BASE: addr_base <= wr_word[5:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_sto_on;
        is_sto && sto_ok && sto_code == 2'h2 |=> drive[$past(target_driver_select)];
    endproperty
    a_sto_on: assert property (p_sto_on) else $error("single output not switched on");

    property p_sto_toggle;
        is_sto && sto_ok && sto_code == 2'h3 |=> drive[$past(target_driver_select)] != $past(sel_bit_now);
    endproperty
    a_sto_toggle: assert property (p_sto_toggle) else $error("single output not inverted");

    property p_sto_off;
        is_sto && sto_ok && sto_code == 2'h1 |=> !drive[$past(target_driver_select)];
    endproperty
    a_sto_off: assert property (p_sto_off) else $error("single output not switched off");

    property p_sto_keep;
        is_sto && sto_code == 2'h0 |=> drive == $past(drive);
    endproperty
    a_sto_keep: assert property (p_sto_keep) else $error("keep code changed an output");

    property p_undef;
        is_sto && target_driver_select >= `MCOD_UNDEF_TARGET |=> drive == $past(drive);
    endproperty
    a_undef: assert property (p_undef) else $error("undefined target changed an output");

    property p_no_right;
        is_sto && !drive_right_config[target_driver_select] |=> drive == $past(drive);
    endproperty
    a_no_right: assert property (p_no_right) else $error("output changed without drive right");

    property p_stoc;
        is_stoc && comp_right[comp_block_select]
            |=> comp_enable[$past(comp_block_select)] == $past(comp_sw);
    endproperty
    a_stoc: assert property (p_stoc) else $error("compensation switch not applied");

    property p_comp_reset;
        disable iff (1'b0) rst |=> comp_enable == 4'h0 && edge_speed_select == 1'b0;
    endproperty
    a_comp_reset: assert property (p_comp_reset) else $error("compensation not off after reset");

    property p_slew_right;
        is_slew && !slew_ok |=> edge_speed_select == $past(edge_speed_select);
    endproperty
    a_slew_right: assert property (p_slew_right) else $error("edge speed changed without rights");

    property p_flag;
        is_flag |=> flags[$past(flag_bit_index)] == $past(flag_level);
    endproperty
    a_flag: assert property (p_flag) else $error("status bit not written");

    property p_stos_keep;
        is_stos && instr.word[5:0] == 6'h00 |=> drive == $past(drive);
    endproperty
    a_stos_keep: assert property (p_stos_keep) else $error("shortcut keep codes changed outputs");

endmodule : mcod_decode
`default_nettype wire

// [test/mcod_seq_model.sv]
/*
 * Sequencer model: presents one instruction word for one cycle per call.
 * Assumes calls come from a single bench process on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module mcod_seq_model (
    input wire logic clock,
    output var mcod_pkg::mcod_instr_t instr
);
    import mcod_pkg::*;

    initial instr = '0;

    // Idle word and source are inverted so that no stale value lingers.
    task automatic issue(input logic [15:0] word, input logic [15:0] src);
        @(posedge clock);
        instr <= '{valid: 1'b1, word: word, src_value: src};
        @(posedge clock);
        instr <= '{valid: 1'b0, word: ~word, src_value: ~src};
    endtask : issue
endmodule : mcod_seq_model

`default_nettype wire

// [test/microcore_output_instr_decode_tb.sv]
/*
 * Self-checking bench of the microcore output instruction decoder.
 * Assumes the sequencer model file and the design package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHECK_EQ(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module microcore_output_instr_decode_tb;
    import mcod_pkg::*;
    logic clock, rst, ce, avs_read, avs_write, avs_waitrequest, edge_speed_fast, lv;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, comp_enable, exp_comp, sel;
    logic [4:0] hs_drive;
    logic [6:0] ls_drive;
    logic [15:0] flags, exp_flags, src;
    logic [11:0] exp_drv;
    logic [5:0] base, a;
    logic [1:0] code;
    mcod_instr_t instr;
    mcod_dram_wr_t dram_wr;
    int n_mismatch, tests_run, cyc;

    mcod_decode i_mcod_decode (.clock(clock), .rst(rst), .ce(ce), .instr(instr),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hs_drive(hs_drive),
        .ls_drive(ls_drive), .comp_enable(comp_enable), .edge_speed_fast(edge_speed_fast),
        .dram_wr(dram_wr), .flags(flags));
    mcod_seq_model i_mcod_seq_model (.clock(clock), .instr(instr));

    // Expected drive vector after one code on one target.
    function automatic logic [11:0] apply_code(logic [11:0] v, logic [3:0] s, logic [1:0] c);
        if (s > 4'hB) return v;
        case (c)
            2'h1: v[s] = 1'b0;
            2'h2: v[s] = 1'b1;
            2'h3: v[s] = ~v[s];
            default: ;
        endcase
        return v;
    endfunction : apply_code

    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clock);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        `CHECK_EQ("waitrequest", 1'b0, avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic run(input logic [15:0] w, input logic [15:0] s);
        i_mcod_seq_model.issue(w, s);
        #1;
    endtask : run

    task automatic wrap_up;
        $display("mismatches %0d in %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        void'($urandom(6737));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHECK_EQ("comp", 4'h0, comp_enable);
        `CHECK_EQ("speed", 1'b0, edge_speed_fast);
        bus(1'b0, 8'h3C, 32'h0);
        `CHECK_EQ("unmapped", 32'h0, rd);
        // Without rights nothing may change and nothing stalls.
        run({10'b0011010010, 4'h2, 2'h2}, 16'h0);
        `CHECK_EQ("drive", 12'h000, {ls_drive, hs_drive});
        run({15'b001101011001011, 1'b1}, 16'h0);
        `CHECK_EQ("speed", 1'b0, edge_speed_fast);
        run({13'b0011010101010, 1'b1, 2'h1}, 16'h0);
        `CHECK_EQ("comp", 4'h0, comp_enable);
        bus(1'b1, 8'h00, 32'hFFF);
        bus(1'b1, 8'h04, 32'hF);
        exp_drv = 12'h000;
        repeat (40) begin
            sel = 4'($urandom_range(12));
            code = 2'($urandom_range(3));
            run({10'b0011010010, sel, code}, 16'h0);
            exp_drv = apply_code(exp_drv, sel, code);
            `CHECK_EQ("drive", exp_drv, {ls_drive, hs_drive});
        end
        exp_comp = 4'h0;
        for (int i = 0; i < 8; i++) begin
            run({13'b0011010101010, i < 4, 2'(i)}, 16'h0);
            exp_comp[2'(i)] = i < 4;
            `CHECK_EQ("comp", exp_comp, comp_enable);
        end
        base = 6'($urandom_range(1, 63));
        bus(1'b1, 8'h0C, {26'h0, base});
        for (int i = 0; i < 6; i++) begin
            a = (i < 2) ? 6'h3F : 6'($urandom);
            src = 16'($urandom);
            run({2'b10, i[0], 5'($urandom), a, 2'b01}, src);
            `CHECK_EQ("we", 1'b1, dram_wr.we);
            `CHECK_EQ("addr", i[0] ? a + base : a, dram_wr.addr);
            `CHECK_EQ("data", src, dram_wr.data);
        end
        // Shortcuts HS4, LS6 and LS3.
        bus(1'b1, 8'h08, 32'h7A3);
        run({10'b0011010001, 2'h3, 2'h2, 2'h1}, 16'h0);
        exp_drv = apply_code(apply_code(apply_code(exp_drv, 4'h3, 2'h3), 4'hA, 2'h2), 4'h7, 2'h1);
        `CHECK_EQ("shortcut", exp_drv, {ls_drive, hs_drive});
        run({10'b0011010001, 6'h00}, 16'h0);
        `CHECK_EQ("shortcut", exp_drv, {ls_drive, hs_drive});
        run({10'b0011010010, 4'hC, 2'h3}, 16'h0);
        `CHECK_EQ("drive", exp_drv, {ls_drive, hs_drive});
        bus(1'b0, 8'h10, 32'h0);
        `CHECK_EQ("state", {20'h0, exp_drv}, rd);
        // A low clock enable must freeze the outputs against a valid instruction.
        @(posedge clock);
        ce <= 1'b0;
        run({10'b0011010010, 4'h0, 2'h3}, 16'h0);
        `CHECK_EQ("frozen", exp_drv, {ls_drive, hs_drive});
        @(posedge clock);
        ce <= 1'b1;
        run({15'b001101011001011, 1'b1}, 16'h0);
        `CHECK_EQ("speed", 1'b1, edge_speed_fast);
        bus(1'b0, 8'h14, 32'h0);
        `CHECK_EQ("mode", {26'h0, 2'b11, exp_comp}, rd);
        run({15'b001101011001011, 1'b0}, 16'h0);
        repeat (2) @(posedge clock);
        #1;
        `CHECK_EQ("speed", 1'b1, edge_speed_fast);
        @(posedge clock);
        #1;
        `CHECK_EQ("speed", 1'b0, edge_speed_fast);
        // Reset in mid-run must switch compensation off again.
        run({13'b0011010101010, 1'b1, 2'h0}, 16'h0);
        `CHECK_EQ("comp", 4'h1, comp_enable);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        `CHECK_EQ("comp", 4'h0, comp_enable);
        `CHECK_EQ("speed", 1'b0, edge_speed_fast);
        exp_flags = 16'h0;
        repeat (20) begin
            sel = 4'($urandom);
            lv = 1'($urandom);
            run({11'b00110111000, lv, sel}, 16'h0);
            exp_flags[sel] = lv;
            `CHECK_EQ("flags", exp_flags, flags);
        end
        wrap_up();
    end
endmodule : microcore_output_instr_decode_tb

`default_nettype wire
